// ---- rtl/acsb_pkg.sv ----
// constants shared by the adapter's status, bus and start-detect logic
// assumes a single 250 MHz clock; bit clocks arrive as sampled inputs
package acsb_pkg;
  // status bit positions
  localparam int SR_FULL  = 0;
  localparam int SR_EMPTY = 1;
  localparam int SR_DCD   = 2;
  localparam int SR_CTS   = 3;
  localparam int SR_FE    = 4;
  localparam int SR_OVR   = 5;
  localparam int SR_PE    = 6;
  localparam int SR_IRQ   = 7;
  // control fields
  localparam int CR_RIE   = 7;
  localparam logic [1:0] DIV_1     = 2'h0;
  localparam logic [1:0] DIV_16    = 2'h1;
  localparam logic [1:0] DIV_64    = 2'h2;
  localparam logic [1:0] DIV_MRST  = 2'h3;
  localparam logic [1:0] TC_TXIRQ  = 2'h1;
  localparam logic [2:0] WS_8_2_NP = 3'h4;
  localparam logic [2:0] WS_8_1_NP = 3'h5;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // start-bit timing in receive clock edges
  localparam logic [5:0] CONF_16   = 6'h08;
  localparam logic [5:0] CONF_64   = 6'h1F;
  localparam logic [5:0] PER_16    = 6'h0F;
  localparam logic [5:0] PER_64    = 6'h3F;
  localparam logic [5:0] CNT_ZERO  = 6'h00;
  localparam logic [5:0] CNT_ONE   = 6'h01;
  typedef enum logic [2:0] {
    SD_IDLE = 3'b001,
    SD_CONF = 3'b010,
    SD_RUN  = 3'b100
  } acsb_sd_t;
endpackage : acsb_pkg

// ---- rtl/acsb_core.sv ----
// status flags, processor bus port and receive start detection
// assumes bus and bit clock pins are synchronous to clk; shifters sit outside
`timescale 1ns/1ps
module acsb_core #(
  parameter int DATA_W = 8
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                cs,
  input  wire logic                rnw,
  input  wire logic                register_select,
  input  wire logic                e,
  input  wire logic [DATA_W-1:0]   di,
  output logic [DATA_W-1:0]        do_data,
  input  wire logic                txclk,
  input  wire logic                rxclk,
  input  wire logic                rxdata,
  input  wire logic                cts_n,
  input  wire logic                dcd_n,
  input  wire logic                rx_load,
  input  wire logic [DATA_W-1:0]   rx_word,
  input  wire logic                rx_frame_bad,
  input  wire logic                rx_parity_bad,
  input  wire logic                rx_overrun,
  input  wire logic                rx_done,
  input  wire logic                tx_moved,
  output logic [DATA_W-1:0]        tx_holding_register,
  output logic                     tx_full,
  output logic                     rx_full,
  output logic [DATA_W-1:0]        ctrl_out,
  output logic                     master_reset,
  output logic                     start_found,
  output logic                     bit_tick,
  output logic                     irq_n
);
  import acsb_pkg::*;

  // ==========================================================
  // elaboration check
  if (DATA_W != 8) begin : g_bad_width
    $error("acsb_core serves an 8-bit bus only");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rx_holding_register;
    logic [7:0] tx_hold;
    logic [7:0] dout;
    logic       full;
    logic       empty;
    logic       dcd;
    logic       cts;
    logic       cts_seen;
    logic       framing_error;
    logic       ovr;
    logic       ovr_pend;
    logic       parity_error;
    logic       irq_n;
    logic       rx_read_seen;
    logic       e_prev;
    logic       tx_prev;
    logic       rx_prev;
    logic       dcd_prev;
    logic       acc_cs;
    logic       acc_rnw;
    logic       acc_sel;
    logic       acc_ok;
    acsb_sd_t   sd;
    logic [5:0] cnt;
    logic       start_p;
    logic       tick_p;
    logic       mrst_out;
  } acsb_state_t;

  acsb_state_t st_reg;
  acsb_state_t st_next;

  logic e_rise;
  logic e_fall;
  logic tx_edge;
  logic rx_edge;
  logic mrst;
  logic commit;
  logic rd_rx;
  logic rd_sr;
  logic wr_cr;
  logic wr_tx;
  logic load_ok;
  logic par_on;
  logic [5:0] per;
  logic [7:0] sr;

  // ==========================================================
  // edge detection and access decode
  assign e_rise  = e & ~st_reg.e_prev;
  assign e_fall  = ~e & st_reg.e_prev;
  assign tx_edge = txclk & ~st_reg.tx_prev;
  assign rx_edge = rxclk & ~st_reg.rx_prev;
  assign mrst    = (st_reg.ctrl[1:0] == DIV_MRST);
  // committed at strobe fall, only if a txclk rise was seen while high
  assign commit  = e_fall & st_reg.acc_cs & (st_reg.acc_ok | tx_edge);
  assign wr_cr   = commit & ~st_reg.acc_rnw & ~st_reg.acc_sel;
  assign wr_tx   = commit & ~st_reg.acc_rnw & st_reg.acc_sel;
  assign rd_sr   = commit & st_reg.acc_rnw & ~st_reg.acc_sel;
  assign rd_rx   = commit & st_reg.acc_rnw & st_reg.acc_sel;
  assign par_on  = (st_reg.ctrl[4:2] != WS_8_2_NP) && (st_reg.ctrl[4:2] != WS_8_1_NP);
  assign load_ok = rx_load & (~st_reg.full | rd_rx);
  assign per     = (st_reg.ctrl[1:0] == DIV_16) ? PER_16 :
                   (st_reg.ctrl[1:0] == DIV_64) ? PER_64 : CNT_ZERO;

  // status image
  always_comb begin
    sr = 8'h00;
    sr[SR_FULL]  = st_reg.full;
    sr[SR_EMPTY] = st_reg.empty & ~st_reg.cts;
    sr[SR_DCD]   = st_reg.dcd;
    sr[SR_CTS]   = st_reg.cts;
    sr[SR_FE]    = st_reg.framing_error;
    sr[SR_OVR]   = st_reg.ovr;
    sr[SR_PE]    = st_reg.parity_error;
    sr[SR_IRQ]   = ~st_reg.irq_n;
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    st_next          = st_reg;
    st_next.e_prev   = e;
    st_next.tx_prev  = txclk;
    st_next.rx_prev  = rxclk;
    st_next.dcd_prev = dcd_n;
    st_next.start_p  = 1'b0;
    st_next.tick_p   = 1'b0;

    // bus capture at strobe rise
    if (e_rise) begin
      st_next.acc_cs  = cs;
      st_next.acc_rnw = rnw;
      st_next.acc_sel = register_select;
      st_next.acc_ok  = tx_edge;
      if (cs && rnw) begin
        st_next.dout = register_select ? st_reg.rx_holding_register : sr;
      end
    end else if (e && tx_edge) begin
      st_next.acc_ok = 1'b1;
    end
    if (e_fall) begin
      st_next.acc_cs = 1'b0;
    end

    if (wr_cr) begin
      st_next.ctrl = di;
    end
    if (wr_tx) begin
      st_next.tx_hold = di;
    end

    // cts follows pin after first txclk rise
    if (tx_edge) begin
      st_next.cts_seen = 1'b1;
    end
    st_next.cts = st_reg.cts_seen ? cts_n : 1'b1;

    if (rd_rx) begin
      st_next.full         = 1'b0;
      st_next.parity_error = 1'b0;
      st_next.ovr          = st_reg.ovr_pend;
      st_next.ovr_pend     = 1'b0;
      st_next.rx_read_seen = 1'b1;
    end
    if (rd_sr && st_reg.rx_read_seen) begin
      st_next.dcd          = 1'b0;
      st_next.rx_read_seen = 1'b0;
    end
    if (wr_tx) begin
      st_next.empty = 1'b0;
    end

    // flag sets win over read and write clears; master reset wins over sets
    // set full on load
    if (load_ok) begin
      st_next.full                = 1'b1;
      st_next.rx_holding_register = rx_word;
      st_next.framing_error       = rx_frame_bad;
      st_next.parity_error        = rx_parity_bad & par_on;
    end
    if (rx_overrun && st_reg.full) begin
      st_next.ovr_pend = 1'b1;
    end
    // set empty on move to shifter
    if (tx_moved) begin
      st_next.empty = 1'b1;
    end
    if (dcd_n && !st_reg.dcd_prev) begin
      st_next.dcd = 1'b1;
    end

    unique case (st_reg.sd)
      SD_IDLE: begin
        if (rx_edge && !rxdata) begin
          st_next.cnt = CNT_ZERO;
          st_next.sd  = (st_reg.ctrl[1:0] == DIV_1) ? SD_RUN : SD_CONF;
          st_next.start_p = (st_reg.ctrl[1:0] == DIV_1);
        end
      end
      SD_CONF: begin
        if (rx_edge) begin
          st_next.cnt = 6'(st_reg.cnt + CNT_ONE);
          if (st_next.cnt == ((st_reg.ctrl[1:0] == DIV_64) ? CONF_64 : CONF_16)) begin
            st_next.cnt = CNT_ZERO;
            // high here is a false start
            st_next.sd      = rxdata ? SD_IDLE : SD_RUN;
            st_next.start_p = ~rxdata;
          end
        end
      end
      SD_RUN: begin
        if (rx_done) begin
          st_next.sd = SD_IDLE;
        end else if (rx_edge) begin
          if (st_reg.cnt == per) begin
            st_next.cnt    = CNT_ZERO;
            st_next.tick_p = 1'b1;
          end else begin
            st_next.cnt = 6'(st_reg.cnt + CNT_ONE);
          end
        end
      end
    endcase

    // master reset clears flags, halts receive
    if (mrst) begin
      st_next.full          = 1'b0;
      st_next.empty         = 1'b0;
      st_next.dcd           = 1'b0;
      st_next.framing_error = 1'b0;
      st_next.ovr           = 1'b0;
      st_next.ovr_pend      = 1'b0;
      st_next.parity_error  = 1'b0;
      st_next.rx_read_seen  = 1'b0;
      st_next.sd            = SD_IDLE;
      st_next.cnt           = CNT_ZERO;
      st_next.start_p       = 1'b0;
      st_next.tick_p        = 1'b0;
    end

    st_next.irq_n = ~((st_next.ctrl[CR_RIE] & (st_next.full | st_next.dcd | st_next.ovr))
                    | ((st_next.ctrl[6:5] == TC_TXIRQ) & st_next.empty & ~cts_n));
    st_next.mrst_out = (st_next.ctrl[1:0] == DIV_MRST);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.ctrl  <= CTRL_RST;
      st_reg.cts   <= 1'b1;
      st_reg.irq_n <= 1'b1;
      st_reg.sd    <= SD_IDLE;
      st_reg.dcd_prev <= 1'b1; // no false carrier rise after clear
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign do_data             = st_reg.dout;
  assign tx_holding_register = st_reg.tx_hold;
  assign tx_full             = ~st_reg.empty;
  assign rx_full             = st_reg.full;
  assign ctrl_out            = st_reg.ctrl;
  assign master_reset        = st_reg.mrst_out;
  assign start_found         = st_reg.start_p;
  assign bit_tick            = st_reg.tick_p;
  assign irq_n               = st_reg.irq_n;

  // ==========================================================
  // checks
  a_full_load: assert property (@(posedge clk) disable iff (!nrst)
    (load_ok && !mrst) |=> rx_full) else $error("full not set after load");
  a_full_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd_rx && !rx_load) |=> !rx_full) else $error("full not cleared by read");
  a_empty_cts: assert property (@(posedge clk) disable iff (!nrst)
    (e_rise && cs && rnw && !register_select && st_reg.cts) |=> !do_data[SR_EMPTY])
    else $error("empty shown with cts high");
  a_empty_write: assert property (@(posedge clk) disable iff (!nrst)
    (wr_tx && !tx_moved) |=> tx_full) else $error("empty not cleared by write");
  a_dcd_hold: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.dcd && !rd_sr && !mrst) |=> st_reg.dcd) else $error("carrier bit dropped");
  a_parity_off: assert property (@(posedge clk) disable iff (!nrst)
    (load_ok && !par_on) |=> !st_reg.parity_error) else $error("parity error with no parity");
  a_irq_bit: assert property (@(posedge clk) disable iff (!nrst)
    (e_rise && cs && rnw && !register_select) |=> (do_data[SR_IRQ] != $past(irq_n)))
    else $error("irq bit not inverse of pin");
  a_mrst_clear: assert property (@(posedge clk) disable iff (!nrst)
    mrst |=> (!rx_full && !st_reg.dcd && !st_reg.ovr && !start_found))
    else $error("master reset left flags set");
  a_div16_conf: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.sd == SD_CONF && rx_edge && st_reg.cnt == CNT_ZERO && !mrst
     && st_reg.ctrl[1:0] == DIV_16) |=> st_reg.sd == SD_CONF)
    else $error("confirm ended too early");
  a_false_start: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.sd == SD_CONF && st_next.sd != SD_CONF && rxdata && !mrst)
    |=> (st_reg.sd == SD_IDLE && !start_found)) else $error("false start accepted");
  a_cts_forced: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.cts_seen && !tx_edge) |=> (st_reg.cts && !st_reg.cts_seen))
    else $error("cts bit not forced after clear");
  a_dcd_set: assert property (@(posedge clk) disable iff (!nrst)
    (dcd_n && !st_reg.dcd_prev && !mrst) |=> st_reg.dcd)
    else $error("carrier rise not latched");
  a_fe_clean: assert property (@(posedge clk) disable iff (!nrst)
    (load_ok && !rx_frame_bad && !mrst) |=> !st_reg.framing_error)
    else $error("framing error kept after clean load");
  a_ovr_show: assert property (@(posedge clk) disable iff (!nrst)
    (rd_rx && st_reg.ovr_pend && !mrst) |=> st_reg.ovr)
    else $error("pending overrun not shown at read");
  a_wr_ctrl: assert property (@(posedge clk) disable iff (!nrst)
    wr_cr |=> (ctrl_out == $past(di)))
    else $error("control write data not taken");
  a_rd_data: assert property (@(posedge clk) disable iff (!nrst)
    (e_rise && cs && rnw && register_select)
    |=> (do_data == $past(st_reg.rx_holding_register)))
    else $error("receive data not shown at strobe rise");
endmodule : acsb_core

// ---- verification/acsb_far.sv ----
// far-side model: free running bit clocks and the serial receive line
// assumes the bench steers line_lvl; the line idles high
`timescale 1ns/1ps
module acsb_far #(
  parameter int TX_HALF = 8,
  parameter int RX_HALF = 16
) (
  output logic txclk,
  output logic rxclk,
  output logic rxdata
);
  logic line_lvl = 1'b1;
  logic line_q   = 1'b1;
  // ==========================================================
  // clocks
  // free running txclk
  initial begin
    txclk = 1'b0;
    #1;
    forever #(TX_HALF) txclk = ~txclk;
  end
  // receive clock, phase unrelated to txclk and clk
  initial begin
    rxclk = 1'b0;
    #3;
    forever #(RX_HALF) rxclk = ~rxclk;
  end
  // ==========================================================
  // serial line
  // line moves on falling rxclk, away from the sampling edge
  always @(negedge rxclk) line_q <= line_lvl;
  assign rxdata = line_q;
endmodule : acsb_far

// ---- verification/acia_status_bus_rx_start_tb.sv ----
// bench for acsb_core: bus tasks, status flag tests, start-bit timing
// assumes acsb_far makes txclk, rxclk and rxdata
`timescale 1ns/1ps
module acia_status_bus_rx_start_tb;
  import acsb_pkg::*;
  logic       clk, nrst, cs, rnw, register_select, e, cts_n, dcd_n, tx_moved;
  logic       rx_load, rx_frame_bad, rx_parity_bad, rx_overrun, rx_done;
  logic [7:0] di, rx_word, do_data, tx_holding_register, ctrl_out, q;
  logic       tx_full, rx_full, master_reset, start_found, bit_tick, irq_n;
  wire        txclk, rxclk, rxdata;
  int         n_fail, check_count, rcnt, sf_cnt, r0;
  logic [1:0] dv [3] = '{DIV_1, DIV_16, DIV_64};
  logic [7:0] cf [3] = '{8'h00, 8'h08, 8'h1F};
  logic [7:0] pd [3] = '{8'h01, 8'h10, 8'h40};
  // ==========================================================
  // instances
  acsb_far far (.txclk(txclk), .rxclk(rxclk), .rxdata(rxdata));
  acsb_core dut (.clk(clk), .nrst(nrst), .cs(cs), .rnw(rnw),
    .register_select(register_select), .e(e), .di(di), .do_data(do_data),
    .txclk(txclk), .rxclk(rxclk), .rxdata(rxdata), .cts_n(cts_n), .dcd_n(dcd_n),
    .rx_load(rx_load), .rx_word(rx_word), .rx_frame_bad(rx_frame_bad),
    .rx_parity_bad(rx_parity_bad), .rx_overrun(rx_overrun), .rx_done(rx_done),
    .tx_moved(tx_moved), .tx_holding_register(tx_holding_register),
    .tx_full(tx_full), .rx_full(rx_full), .ctrl_out(ctrl_out),
    .master_reset(master_reset), .start_found(start_found), .bit_tick(bit_tick),
    .irq_n(irq_n));
  // ==========================================================
  // clock and monitors
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count receive clock rises and confirmed starts
  always @(posedge rxclk) rcnt++;
  always @(negedge clk) if (start_found === 1'b1) sf_cnt++;
  // ==========================================================
  // tasks
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    check_count++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", n, x, g);
      n_fail++;
    end
  endtask : chk
  // selects set first, strobe spans txclk rises
  task automatic acc(input logic c, input logic r, input logic s, input logic [7:0] d);
    cs = c;
    rnw = r;
    register_select = s;
    di = d;
    tick;
    e = 1'b1;
    repeat (10) tick;
    e = 1'b0;
    repeat (2) tick;
    q = do_data;
    cs = 1'b0;
    tick;
  endtask : acc
  task automatic wr(input logic s, input logic [7:0] d);
    acc(1'b1, 1'b0, s, d);
  endtask : wr
  task automatic st(input logic [7:0] x);
    acc(1'b1, 1'b1, 1'b0, 8'h00);
    chk("status", x, q);
  endtask : st
  task automatic rd(input logic [7:0] x);
    acc(1'b1, 1'b1, 1'b1, 8'h00);
    chk("rx data", x, q);
  endtask : rd
  task automatic ld(input logic [7:0] w, input logic f, input logic p);
    rx_word = w;
    rx_frame_bad = f;
    rx_parity_bad = p;
    rx_load = 1'b1;
    tick;
    rx_load = 1'b0;
    tick;
  endtask : ld
  // wait a bounded time for start_found (b=0) or bit_tick (b=1)
  task automatic wp(input bit b);
    bit hit;
    hit = 1'b0;
    for (int k = 0; k < 4000 && !hit; k++) begin
      tick;
      hit = ((b ? bit_tick : start_found) === 1'b1);
    end
    if (!hit) begin
      $display("MISMATCH wait pulse expected 1 seen 0");
      n_fail++;
    end
  endtask : wp
  task automatic stop_test;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ==========================================================
  // watchdog
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    {cs, rnw, register_select, e, cts_n, dcd_n, tx_moved} = '0;
    {rx_load, rx_frame_bad, rx_parity_bad, rx_overrun, rx_done} = '0;
    di = 8'h00;
    rx_word = 8'h00;
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    // first txclk rise is seen only one clk before the strobe rise: cts bit still forced
    st(8'h08);
    wr(1'b0, {1'b1, 2'b00, WS_8_1_NP, DIV_16});
    chk("control", {1'b1, 2'b00, WS_8_1_NP, DIV_16}, ctrl_out);
    wr(1'b1, 8'hA5);
    chk("tx hold", 8'hA5, tx_holding_register);
    chk("tx full", 8'h01, {7'h00, tx_full});
    st(8'h00);
    tx_moved = 1'b1;
    tick;
    tx_moved = 1'b0;
    st(8'h02);
    cts_n = 1'b1;
    repeat (10) tick;
    st(8'h08);
    cts_n = 1'b0;
    repeat (10) tick;
    acc(1'b0, 1'b0, 1'b1, 8'h5A);
    chk("tx hold", 8'hA5, tx_holding_register);
    ld(8'h3C, 1'b1, 1'b1);
    chk("irq", 8'h00, {7'h00, irq_n});
    st(8'h93);
    rx_overrun = 1'b1;
    tick;
    rx_overrun = 1'b0;
    st(8'h93);
    rd(8'h3C);
    st(8'hB2);
    rd(8'h3C);
    st(8'h12);
    ld(8'hC3, 1'b0, 1'b0);
    st(8'h83);
    rd(8'hC3);
    st(8'h02);
    wr(1'b0, {1'b1, 2'b00, 3'h6, DIV_16});
    ld(8'h77, 1'b0, 1'b1);
    st(8'hC3);
    rd(8'h77);
    st(8'h02);
    dcd_n = 1'b1;
    repeat (4) tick;
    st(8'h86);
    dcd_n = 1'b0;
    st(8'h86);
    st(8'h86);
    rd(8'h77);
    st(8'h86);
    st(8'h02);
    ld(8'h11, 1'b1, 1'b1);
    wr(1'b0, {6'h00, DIV_MRST});
    chk("master reset", 8'h01, {7'h00, master_reset});
    chk("rx full", 8'h00, {7'h00, rx_full});
    st(8'h00);
    // receive enable low: a full holding register raises no interrupt
    wr(1'b0, {1'b0, 2'b00, WS_8_1_NP, DIV_16});
    ld(8'h5E, 1'b0, 1'b0);
    chk("irq", 8'h01, {7'h00, irq_n});
    st(8'h01);
    rd(8'h5E);
    // transmit interrupt term once the holding register empties
    wr(1'b0, {1'b0, TC_TXIRQ, WS_8_1_NP, DIV_16});
    tx_moved = 1'b1;
    tick;
    tx_moved = 1'b0;
    chk("tx irq", 8'h00, {7'h00, irq_n});
    st(8'h82);
    for (int m = 0; m < 3; m++) begin
      wr(1'b0, {3'h0, WS_8_1_NP, dv[m]});
      far.line_lvl = 1'b0;
      @(negedge rxclk);
      #1;
      r0 = rcnt;
      wp(1'b0);
      chk("confirm edges", cf[m], 8'(rcnt - r0 - 1));
      far.line_lvl = 1'b1;
      r0 = rcnt;
      wp(1'b1);
      chk("bit period", pd[m], 8'(rcnt - r0));
      rx_done = 1'b1;
      tick;
      rx_done = 1'b0;
    end
    far.line_lvl = 1'b0;
    @(negedge rxclk);
    @(posedge rxclk);
    far.line_lvl = 1'b1;
    r0 = sf_cnt;
    repeat (40) @(posedge rxclk);
    chk("false start", 8'(r0), 8'(sf_cnt));
    stop_test;
  end
endmodule : acia_status_bus_rx_start_tb
